// ==== rtl/dac_playback_pkg.sv ====
// Constants, register map and types for the DAC waveform playback block
package dac_playback_pkg;
   localparam int NCH   = 8;
   localparam int CW    = 3;
   localparam int DW    = 16;
   localparam int DEPTH = 4096;
   localparam int PW    = 12;
   localparam int LW    = 13;
   localparam int EW    = CW + 1 + DW;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_MASK   = 8'h04;
   localparam logic [7:0] OFF_LEN    = 8'h08;
   localparam logic [7:0] OFF_DATA   = 8'h0c;
   localparam logic [7:0] OFF_TICK   = 8'h10;
   localparam logic [7:0] OFF_DIRECT = 8'h14;
   localparam logic [7:0] OFF_DEPTH  = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [2:0] trig_src_none       = 3'h0;
   localparam logic [2:0] trig_src_soft_tick  = 3'h1;
   localparam logic [2:0] trig_src_ext_rise   = 3'h2;
   localparam logic [2:0] trig_src_ext_fall   = 3'h3;
   localparam logic [2:0] trig_src_timer_out0 = 3'h4;
   localparam logic [2:0] trig_src_timer_out1 = 3'h5;
   localparam logic [2:0] trig_src_timer_out2 = 3'h6;
   localparam logic [1:0] mode_direct = 2'h0;
   localparam logic [1:0] mode_fifo   = 2'h1;
   localparam logic [1:0] mode_play   = 2'h2;
   localparam logic [2:0]  SRC_RESET  = 3'h0;
   localparam logic [1:0]  MODE_RESET = 2'h0;
   localparam logic [7:0]  MASK_RESET = 8'h00;
   localparam logic [LW-1:0] LEN_RESET = 13'h0000;
   localparam logic [31:0] DEPTH_WORD = 32'h00001000;
   typedef enum logic {seq_idle, seq_emit} seq_state_e;
endpackage

// ==== rtl/dac_waveform_playback.sv ====
// Waveform playback sequencer with APB registers and two-entry DAC buffer
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
// What this block does
// RL1 - Trigger source selectable; falling external edge is 3, timer output 0 is 4.
// RL2 - Trigger only acts in FIFO or playback mode, never in direct mode.
// RL3 - Each tick sends the next stored frame, one sample per enabled channel.
// RL4 - In playback mode, after the last frame, the next tick starts again at the first frame; FIFO mode stops.
// RL5 - Zero length, a new waveform or a direct write stops playback.
// RL6 - The buffer holds up to 4096 samples and software can read its depth.
// RL7 - Frame samples go to enabled channels from lowest mask bit upward.
// RL8 - Only low 16 bits are used; bipolar channels treat them as signed.
// RL9 - Software loads whole frames, total not above the buffer depth.
// RL10 - Only channels with a set mask bit receive frame data; direct writes reach any channel.
// RL11 - A software tick advances one step, only when source is software.
// RL12 - None is 0, software 1, rising edge 2, timer 1 is 5, timer 2 is 6.
module dac_waveform_playback
   import dac_playback_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          ext_trig,
   input  wire logic [2:0]    timer_out,
   output logic               dac_valid,
   input  wire logic          dac_ready,
   output logic      [CW-1:0] dac_chan,
   output logic               dac_bipolar,
   output logic      [DW-1:0] dac_data
);
   function automatic logic [CW:0] next_chan(input logic [NCH-1:0] m, input logic [CW:0] from);
      logic [CW:0] r;
      r = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (m[i] && (CW + 1)'(i) >= from) begin
            r = {1'b1, CW'(i)};
         end
      end
      return r;
   endfunction

   logic [3:0]      sync1, sync2, prev;
   logic [3:0]      rise, fall;
   logic [1:0]      mode, next_mode;
   logic [2:0]      src, next_src;
   logic [NCH-1:0]  mask, next_mask, bipolar, next_bipolar;
   logic [LW-1:0]   len, next_len, wr_ptr, next_wr_ptr;
   logic            playing, next_playing, loading, next_loading;
   logic            soft_tick, next_soft_tick;
   logic            next_pready, next_pslverr;
   logic [31:0]     next_prdata;
   seq_state_e      state, next_state;
   logic [PW-1:0]   rd_ptr, next_rd_ptr;
   logic [CW-1:0]   cur_ch, next_cur_ch;
   logic            drained, next_drained;
   logic [EW-1:0]   b0, b1, next_b0, next_b1, in_data;
   logic            v0, v1, next_v0, next_v1;
   logic            in_ready, in_valid, seq_push, dir_push;
   logic            acc, wr, stop, dir_block, tick, tick_ok, mem_we;
   logic [CW:0]     first_ch, after_ch;
   logic [DW-1:0]   wave_mem [DEPTH];

   // Pins cross in through two flops; edges only look at stage two
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         prev  <= 4'h0;
      end else begin
         sync1 <= {timer_out, ext_trig};
         sync2 <= sync1;
         prev  <= sync2;
      end
   end
   assign rise = sync2 & ~prev;
   assign fall = ~sync2 & prev;

   always_comb begin
      case (src)
         trig_src_soft_tick:  tick = soft_tick; // RL11
         trig_src_ext_rise:   tick = rise[0]; // RL12
         trig_src_ext_fall:   tick = fall[0]; // RL1
         trig_src_timer_out0: tick = rise[1]; // RL1
         trig_src_timer_out1: tick = rise[2]; // RL12
         trig_src_timer_out2: tick = rise[3]; // RL12
         default:             tick = 1'b0; // RL12
      endcase
   end

   assign acc       = psel & penable & pready;
   assign wr        = acc & pwrite;
   assign stop      = wr & ((paddr == OFF_LEN) | (paddr == OFF_DIRECT)); // RL5
   // Direct writes wait out a frame in flight rather than interleave with it
   assign dir_block = pwrite & (paddr == OFF_DIRECT) &
                      ((state != seq_idle) | tick_ok | ~in_ready);
   assign mem_we    = wr & (paddr == OFF_DATA) & loading;

   always_comb begin
      next_pready  = psel & penable & ~pready & ~dir_block;
      next_prdata  = 32'h0;
      next_pslverr = 1'b0;
      if (next_pready) begin
         case (paddr)
            OFF_CTRL:   next_prdata = {27'h0, mode, src};
            OFF_MASK:   next_prdata = {16'h0, bipolar, mask};
            OFF_LEN:    next_prdata = {19'h0, len};
            OFF_DEPTH:  next_prdata = DEPTH_WORD; // RL6
            OFF_STATUS: next_prdata = {playing, state == seq_emit, loading, drained,
                                       rd_ptr, 3'h0, wr_ptr};
            OFF_DATA, OFF_TICK, OFF_DIRECT: next_prdata = 32'h0;
            default:    next_pslverr = 1'b1;
         endcase
         // Read-only registers refuse writes
         if (pwrite) begin
            next_prdata  = 32'h0;
            next_pslverr = next_pslverr | (paddr == OFF_DEPTH) | (paddr == OFF_STATUS);
         end
      end
   end

   always_comb begin
      next_mode      = mode;
      next_src       = src;
      next_mask      = mask;
      next_bipolar   = bipolar;
      next_len       = len;
      next_wr_ptr    = wr_ptr;
      next_playing   = playing;
      next_loading   = loading;
      next_soft_tick = wr & (paddr == OFF_TICK) & pwdata[0];
      if (wr) begin
         case (paddr)
            OFF_CTRL: begin
               next_src  = pwdata[2:0];
               next_mode = pwdata[4:3];
            end
            OFF_MASK: begin
               next_mask    = pwdata[7:0];
               next_bipolar = pwdata[15:8];
            end
            OFF_LEN: begin
               // Lengths above the depth are cut; loader must keep within it
               next_len     = (pwdata[31:0] > 32'(DEPTH)) ? LW'(DEPTH) : pwdata[LW-1:0]; // RL9
               next_wr_ptr  = '0;
               next_playing = 1'b0; // RL5
               next_loading = (pwdata[LW-1:0] != '0) && (pwdata[31:LW] == '0); // RL5
            end
            OFF_DATA: begin
               if (loading) begin
                  next_wr_ptr = wr_ptr + 1'b1;
                  if (wr_ptr + 1'b1 == len) begin
                     next_loading = 1'b0;
                     next_playing = 1'b1;
                  end
               end
            end
            OFF_DIRECT: {next_playing, next_loading} = 2'b00; // RL5
            default: next_playing = playing;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode      <= MODE_RESET;
         src       <= SRC_RESET;
         mask      <= MASK_RESET;
         bipolar   <= MASK_RESET;
         len       <= LEN_RESET;
         wr_ptr    <= LEN_RESET;
         playing   <= 1'b0;
         loading   <= 1'b0;
         soft_tick <= 1'b0;
         pready    <= 1'b0;
         prdata    <= 32'h0;
         pslverr   <= 1'b0;
      end else begin
         mode      <= next_mode;
         src       <= next_src;
         mask      <= next_mask;
         bipolar   <= next_bipolar;
         len       <= next_len;
         wr_ptr    <= next_wr_ptr;
         playing   <= next_playing;
         loading   <= next_loading;
         soft_tick <= next_soft_tick;
         pready    <= next_pready;
         prdata    <= next_prdata;
         pslverr   <= next_pslverr;
      end
   end

   // The buffer is the FIFO; no reset, contents are reloaded before use
   always_ff @(posedge clk) begin
      if (mem_we) begin
         wave_mem[wr_ptr[PW-1:0]] <= pwdata[DW-1:0]; // RL8
      end
   end

   assign tick_ok  = tick & playing & ~drained & (state == seq_idle) &
                     ((mode == mode_fifo) | (mode == mode_play)); // RL2
   assign first_ch = next_chan(mask, '0); // RL7
   assign after_ch = next_chan(mask, {1'b0, cur_ch} + 1'b1); // RL7
   assign seq_push = (state == seq_emit) & in_ready; // RL3
   assign dir_push = wr & (paddr == OFF_DIRECT);

   always_comb begin
      next_state   = state;
      next_rd_ptr  = rd_ptr;
      next_cur_ch  = cur_ch;
      next_drained = drained;
      if (stop) begin
         next_state   = seq_idle; // RL5
         next_rd_ptr  = '0;
         next_drained = 1'b0;
      end else begin
         case (state)
            seq_idle: begin
               // A tick during a frame in flight is dropped, not queued
               if (tick_ok && first_ch[CW]) begin
                  next_state  = seq_emit; // RL3
                  next_cur_ch = first_ch[CW-1:0]; // RL10
               end
            end
            seq_emit: begin
               if (in_ready) begin
                  if ({1'b0, rd_ptr} + 1'b1 == len) begin
                     next_rd_ptr  = '0; // RL4
                     next_drained = (mode != mode_play);
                  end else begin
                     next_rd_ptr = rd_ptr + 1'b1;
                  end
                  if (after_ch[CW]) begin
                     next_cur_ch = after_ch[CW-1:0]; // RL7
                  end else begin
                     next_state = seq_idle;
                  end
               end
            end
            default: next_state = seq_idle;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state   <= seq_idle;
         rd_ptr  <= '0;
         cur_ch  <= '0;
         drained <= 1'b0;
      end else begin
         state   <= next_state;
         rd_ptr  <= next_rd_ptr;
         cur_ch  <= next_cur_ch;
         drained <= next_drained;
      end
   end

   assign in_data  = seq_push ? {cur_ch, bipolar[cur_ch], wave_mem[rd_ptr]} // RL8
                              : {pwdata[18:16], bipolar[pwdata[18:16]], pwdata[DW-1:0]};
   assign in_valid = seq_push | dir_push;
   assign in_ready = ~v1;

   always_comb begin
      next_b0 = b0;
      next_b1 = b1;
      next_v0 = v0;
      next_v1 = v1;
      if (v0 && dac_ready) begin
         next_b0 = b1;
         next_v0 = v1;
         next_v1 = 1'b0;
      end
      if (in_valid) begin
         if (next_v0) begin
            next_b1 = in_data;
            next_v1 = 1'b1;
         end else begin
            next_b0 = in_data;
            next_v0 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         b0 <= '0;
         b1 <= '0;
         v0 <= 1'b0;
         v1 <= 1'b0;
      end else begin
         b0 <= next_b0;
         b1 <= next_b1;
         v0 <= next_v0;
         v1 <= next_v1;
      end
   end
   assign dac_valid   = v0;
   assign dac_chan    = b0[EW-1:EW-CW];
   assign dac_bipolar = b0[DW];
   assign dac_data    = b0[DW-1:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_fall_edge_tick: assert property (src == trig_src_ext_fall && fall[0] && tick_ok && // RL1
      mask != '0 && !stop |=> state == seq_emit) else $error("fall edge tick lost");
   a_direct_mode_quiet: assert property (state == seq_idle && mode == mode_direct // RL2
      |=> state == seq_idle) else $error("trigger acted in direct mode");
   a_frame_lands: assert property (seq_push |=> v0) else $error("frame sample not buffered"); // RL3
   a_wrap_first: assert property (seq_push && !stop && mode == mode_play && // RL4
      {1'b0, rd_ptr} + 1'b1 == len |=> rd_ptr == '0) else $error("no wrap to first frame");
   a_stop_clears: assert property (stop |=> state == seq_idle && rd_ptr == '0 // RL5
      && !playing) else $error("waveform not stopped");
   a_depth_read: assert property ($rose(pready) && !$past(pwrite) && // RL6
      $past(paddr) == OFF_DEPTH |-> prdata == DEPTH_WORD) else $error("bad depth");
   a_chan_ascend: assert property (seq_push && after_ch[CW] && !stop // RL7
      |=> cur_ch > $past(cur_ch)) else $error("channel order not ascending");
   a_direct_word: assert property (dir_push && !v0 |=> v0 && // RL8
      dac_data == $past(pwdata[15:0]) && dac_bipolar == $past(bipolar[pwdata[18:16]]))
      else $error("direct sample mangled");
   a_mask_only: assert property (seq_push |-> mask[cur_ch]) else $error("unmasked channel"); // RL10
   a_soft_ignored: assert property (soft_tick && src != trig_src_soft_tick && rise == '0 && // RL11
      fall == '0 |-> !tick) else $error("soft tick not ignored");
   a_rise_code: assert property (src == trig_src_ext_rise && rise[0] |-> tick) // RL12
      else $error("rising edge code wrong");

   c_wrap: cover property (seq_push && mode == mode_play && {1'b0, rd_ptr} + 1'b1 == len);
   c_stall: cover property (v1 && !dac_ready);
   c_direct: cover property (dir_push);
   c_fifo_drain: cover property ($rose(drained));
endmodule

// ==== verification/dac_sink_model.sv ====
// DAC converter model that takes buffered samples, with optional stalls
`timescale 1ns/100ps
module dac_sink_model
   import dac_playback_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          stall,
   input  wire logic          dac_valid,
   input  wire logic [CW-1:0] dac_chan,
   input  wire logic          dac_bipolar,
   input  wire logic [DW-1:0] dac_data,
   output logic               dac_ready,
   output logic               got,
   output logic      [EW-1:0] got_word
);
   logic [DW-1:0] level [NCH];

   // Slow mode drops ready most cycles so the two-entry buffer fills
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dac_ready <= 1'b0;
         got       <= 1'b0;
      end else begin
         dac_ready <= stall ? ($urandom % 3 == 0) : 1'b1;
         got       <= dac_valid && dac_ready;
         got_word  <= {dac_bipolar, dac_chan, dac_data};
         if (dac_valid && dac_ready) level[dac_chan] <= dac_data;
      end
   end
endmodule

// ==== verification/dac_waveform_playback_tb.sv ====
// Self-checking bench for the DAC waveform playback block
`timescale 1ns/100ps
module dac_waveform_playback_tb
   import dac_playback_pkg::*;
;
   logic          clk, rst_n, psel, penable, pwrite, ext_trig, stall, err;
   logic          pready, pslverr, dac_valid, dac_ready, dac_bipolar, got;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [2:0]    timer_out;
   logic [CW-1:0] dac_chan;
   logic [DW-1:0] dac_data, dv;
   logic [EW-1:0] got_word, want;
   logic [15:0]   mask;
   logic [31:0]   wave [DEPTH];
   logic [EW-1:0] exp_q [$];
   int            fails, samples_checked, nch, nfr, fidx;
   logic [1:0]    quiet_mode [3] = '{mode_play, mode_play, mode_direct};
   logic [2:0]    quiet_src [3] = '{trig_src_none, trig_src_ext_rise, trig_src_soft_tick};

   dac_waveform_playback dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_trig(ext_trig), .timer_out(timer_out),
      .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_chan(dac_chan),
      .dac_bipolar(dac_bipolar), .dac_data(dac_data));
   dac_sink_model sink (.clk(clk), .rst_n(rst_n), .stall(stall), .dac_valid(dac_valid),
      .dac_chan(dac_chan), .dac_bipolar(dac_bipolar), .dac_data(dac_data),
      .dac_ready(dac_ready), .got(got), .got_word(got_word));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e, input string w);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, w, g, e);
      end
   endtask

   // Request held until pready seen high at the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      check({31'h0, pready}, 32'h1, "bus answer");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
      apb(1'b0, a, 32'h0);
      check(rd, e, w);
   endtask

   task automatic setctrl(input logic [1:0] m, input logic [2:0] s);
      wr(OFF_CTRL, {27'h0, m, s});
   endtask

   task automatic load(input logic [15:0] m, input int len);
      mask = m;
      nch  = $countones(m[7:0]);
      nfr  = len / nch;
      fidx = 0;
      wr(OFF_MASK, {16'h0, m});
      wr(OFF_LEN, 32'(len));
      for (int i = 0; i < len; i++) begin
         wave[i] = $urandom;
         wr(OFF_DATA, wave[i]);
      end
   endtask

   task automatic push_frame();
      int k;
      k = 0;
      for (int ch = 0; ch < NCH; ch++) begin
         if (mask[ch]) begin
            exp_q.push_back({mask[8+ch], 3'(ch), wave[fidx*nch+k][15:0]});
            k++;
         end
      end
      fidx = (fidx + 1) % nfr;
   endtask

   task automatic fire(input logic [2:0] s);
      @(posedge clk);
      if (s == trig_src_soft_tick) wr(OFF_TICK, 32'h1);
      else if (s == trig_src_ext_rise) ext_trig <= 1'b1;
      else if (s == trig_src_ext_fall) ext_trig <= 1'b0;
      else if (s >= trig_src_timer_out0) timer_out[s-3'h4] <= 1'b1;
   endtask

   // Quiet tail catches words that should never have come
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      repeat (20) @(posedge clk);
      timer_out <= 3'h0;
      check(32'(exp_q.size()), 32'h0, "frame missing");
   endtask

   always @(posedge clk) begin
      if (rst_n && got) begin
         samples_checked++;
         if (exp_q.size() == 0) begin
            fails++;
            $display("CHECK FAILED at %0t: unexpected word %h", $time, got_word);
         end else begin
            want = exp_q.pop_front();
            if (got_word !== want) begin
               fails++;
               $display("CHECK FAILED at %0t: word %h want %h", $time, got_word, want);
            end
         end
      end
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      {psel, penable, pwrite, ext_trig, stall} = '0;
      paddr = '0;
      pwdata = '0;
      timer_out = '0;
      rst_n = 1'b0;
      fails = 0;
      samples_checked = 0;
      void'($urandom(37898));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(OFF_CTRL, 32'h0, "ctrl reset");
      rdchk(OFF_DEPTH, DEPTH_WORD, "depth");
      apb(1'b0, 8'h20, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped");
      $display("Test registers done");
      load(16'h080c, 4);
      for (int s = 1; s <= 6; s++) begin
         setctrl(mode_play, 3'(s));
         push_frame();
         fire(3'(s));
         drain();
      end
      $display("Test trigger sources done");
      foreach (quiet_mode[i]) begin
         setctrl(quiet_mode[i], quiet_src[i]);
         fire(trig_src_soft_tick);
         drain();
      end
      $display("Test ignored ticks done");
      stall <= 1'b1;
      setctrl(mode_fifo, trig_src_soft_tick);
      load(16'hf0ff, 16);
      repeat (2) begin
         push_frame();
         fire(trig_src_soft_tick);
         drain();
      end
      stall <= 1'b0;
      $display("Test fifo with stalls done");
      setctrl(mode_play, trig_src_soft_tick);
      load(16'h0003, 4);
      push_frame();
      fire(trig_src_soft_tick);
      drain();
      load(16'h0081, 4);
      push_frame();
      fire(trig_src_soft_tick);
      drain();
      dv = $urandom;
      exp_q.push_back({mask[13], 3'h5, dv});
      wr(OFF_DIRECT, {13'h0, 3'h5, dv});
      drain();
      fire(trig_src_soft_tick);
      drain();
      load(16'h0003, 2);
      wr(OFF_LEN, 32'h0);
      rdchk(OFF_STATUS, 32'h0, "status stopped");
      fire(trig_src_soft_tick);
      drain();
      $display("Test stopping done");
      summarize();
   end
endmodule
